/* File: led_panel.sv */
// observer for one front-panel lamp: counts colour onsets and code changes
`default_nettype none
module led_panel (
    input  wire logic       clk_sys, // system clock
    input  wire logic       clear,   // restart both counts
    input  wire logic [1:0] code,    // colour code on the lamp
    input  wire logic [1:0] colour,  // colour whose onsets count
    output logic      [7:0] rises,   // onsets of colour
    output logic      [7:0] changes  // any code change
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] last;
    // lamp sees only the code; a dark gap between flashes makes a new onset
    always_ff @(posedge clk_sys) begin
        last <= code;
        if (clear) begin
            rises <= 8'h00;
            changes <= 8'h00;
        end else begin
            if (code === colour && last !== colour) rises <= rises + 8'h01;
            if (code !== last) changes <= changes + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: status_led_consts.svh */
// timing and pattern constants for the fieldbus status indicator
`ifndef STATUS_LED_CONSTS_SVH
`define STATUS_LED_CONSTS_SVH
`define LED_TICK_NS        50000000
`define LED_CLK_NS         4
`define LED_TICK_CYCLES    (`LED_TICK_NS / `LED_CLK_NS)
`define LED_PHASE_W        5
`define LED_FLICKER_BIT    0
`define LED_BLINK_BIT      2
`define LED_GROUP_LEN      5'h1f
`define LED_FLASHES_NOPORT 3'h3
`define LED_FLASHES_DUPIP  3'h4
`define LED_FLASHES_DHCP   3'h5
`define LED_FLASHES_SINGLE 3'h1
`define LED_COLOR_OFF      2'h0
`define LED_COLOR_GREEN    2'h1
`define LED_COLOR_RED      2'h2
`define LED_COLOR_YELLOW   2'h3
`define LED_SELFTEST_TICKS 5'h08
`endif

/* File: status_led_indicator.sv */
// fieldbus status led drive: module, network and two port link leds
`include "status_led_consts.svh"
`default_nettype none

// Notes on behaviour
// - internal link error holds module led steady red
// - ready and operational holds module led steady green
// - module led is dark while operating only in the off phases of identification flicker
// - comm interruption, bad config or controller stop flickers module led red
// - no controller connection gives single red flashes on module led
// - identification, flash mode or parameter backup pending flickers network led green
// - no ip address keeps network led off
// - module error holds network led steady red
// - port connected with valid ip holds network led steady green
// - all ports unplugged with ip repeats three green flashes
// - duplicate ip repeats four green flashes
// - dhcp sequence repeats five green flashes
// - port link at 100 mbit/s gives steady green
// - activity at 100 mbit/s blinks green
// - link at 10 mbit/s steady yellow, no link off
// - activity at 10 mbit/s blinks yellow
// - modbus tcp server only mode uses a different status scheme
module status_led_indicator
    import status_led_pkg::*;
#(
    parameter int TICK_CYCLES = `LED_TICK_CYCLES
) (
    input  wire logic       clk_sys,             // system clock
    input  wire logic       resetn,              // synchronous reset, active low
    input  wire logic       clk_en,              // clock enable, freezes state when low
    input  wire logic       internal_link_error, // internal link error seen
    input  wire logic       module_ready,        // module ready and operational
    input  wire logic       comm_fault,          // interruption, bad config or controller stop
    input  wire logic       no_controller,       // no connection to network controller
    input  wire logic       modbus_only,         // modbus tcp server only mode
    input  wire logic       identify_active,     // identification or flash mode
    input  wire logic       param_backup_busy,   // parameter backup/restore pending
    input  wire logic       ip_valid,            // ip address assigned
    input  wire logic       module_error,        // error detected on module
    input  wire logic       dup_ip,              // duplicate ip detected
    input  wire logic       dhcp_busy,           // dhcp sequence in progress
    input  wire logic [1:0] port_link,           // link present per port (a=0, b=1)
    input  wire logic [1:0] port_fast,           // 1 = 100 mbit/s, 0 = 10 mbit/s
    input  wire logic [1:0] port_activity,       // activity pulse or level per port
    output logic      [1:0] module_status_led,   // colour code
    output logic      [1:0] network_status_led,  // colour code
    output logic      [1:0] port_a_link_led,     // colour code
    output logic      [1:0] port_b_link_led      // colour code
);

    led_phase_type phase;
    logic [31:0] prescale;
    logic [`LED_PHASE_W-1:0] step;
    logic [`LED_PHASE_W-1:0] selftest_cnt;
    logic [1:0] act_hold;

    function automatic logic flash_on(input logic [`LED_PHASE_W-1:0] s, input logic [2:0] n);
        // two steps per flash, then dark for the rest of the group
        flash_on = (s < {1'b0, n, 1'b0}) && !s[0];
    endfunction

    function automatic logic [1:0] link_color(input logic link, input logic fast, input logic act,
                                              input logic blink);
        if (!link)
            link_color = `LED_COLOR_OFF;
        else if (act && !blink)
            link_color = `LED_COLOR_OFF;
        else if (fast)
            link_color = `LED_COLOR_GREEN;
        else
            link_color = `LED_COLOR_YELLOW;
    endfunction

    wire tick = (prescale == TICK_CYCLES - 1);
    wire flicker = step[`LED_FLICKER_BIT];
    wire blink = step[`LED_BLINK_BIT];
    wire alt_green = step[`LED_BLINK_BIT];

    logic [1:0] next_module;
    logic [1:0] next_network;

    always_comb begin
        if (phase == led_selftest) begin
            next_module = alt_green ? `LED_COLOR_GREEN : `LED_COLOR_RED;
        end else if (modbus_only) begin
            next_module = module_ready ? `LED_COLOR_GREEN : `LED_COLOR_RED;
        end else if (internal_link_error) begin
            next_module = `LED_COLOR_RED;
        end else if (comm_fault) begin
            next_module = flicker ? `LED_COLOR_RED : `LED_COLOR_OFF;
        end else if (no_controller) begin
            next_module = flash_on(step, `LED_FLASHES_SINGLE) ? `LED_COLOR_RED : `LED_COLOR_OFF;
        end else if (identify_active) begin
            next_module = flicker ? `LED_COLOR_GREEN : `LED_COLOR_OFF;
        end else begin
            next_module = `LED_COLOR_GREEN;
        end
    end

    always_comb begin
        if (phase == led_selftest) begin
            next_network = alt_green ? `LED_COLOR_RED : `LED_COLOR_GREEN;
        end else if (modbus_only) begin
            next_network = ip_valid ? `LED_COLOR_GREEN : `LED_COLOR_OFF;
        end else if (module_error) begin
            next_network = `LED_COLOR_RED;
        end else if (identify_active || param_backup_busy) begin
            next_network = flicker ? `LED_COLOR_GREEN : `LED_COLOR_OFF;
        end else if (dhcp_busy) begin
            next_network = flash_on(step, `LED_FLASHES_DHCP) ? `LED_COLOR_GREEN : `LED_COLOR_OFF;
        end else if (!ip_valid) begin
            next_network = `LED_COLOR_OFF;
        end else if (dup_ip) begin
            next_network = flash_on(step, `LED_FLASHES_DUPIP) ? `LED_COLOR_GREEN : `LED_COLOR_OFF;
        end else if (port_link == 2'h0) begin
            next_network = flash_on(step, `LED_FLASHES_NOPORT) ? `LED_COLOR_GREEN : `LED_COLOR_OFF;
        end else begin
            next_network = `LED_COLOR_GREEN;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            prescale <= '0;
            step <= '0;
        end else if (clk_en) begin
            prescale <= tick ? '0 : prescale + 32'h1;
            if (tick)
                step <= (step == `LED_GROUP_LEN) ? '0 : step + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            phase <= led_selftest;
            selftest_cnt <= '0;
        end else if (clk_en && phase == led_selftest && tick) begin
            selftest_cnt <= selftest_cnt + 1'b1;
            if (selftest_cnt == `LED_SELFTEST_TICKS - 1)
                phase <= led_run;
        end
    end

    // activity is held to the end of the current four-step half blink period so short bursts still show
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            act_hold <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (port_activity[i])
                    act_hold[i] <= 1'b1;
                else if (tick && step[1:0] == 2'h3)
                    act_hold[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            module_status_led <= `LED_COLOR_GREEN;
            network_status_led <= `LED_COLOR_RED;
            port_a_link_led <= `LED_COLOR_OFF;
            port_b_link_led <= `LED_COLOR_OFF;
        end else if (clk_en) begin
            module_status_led <= next_module;
            network_status_led <= next_network;
            port_a_link_led <= link_color(port_link[0], port_fast[0], act_hold[0], blink);
            port_b_link_led <= link_color(port_link[1], port_fast[1], act_hold[1], blink);
        end
    end

    link_err_red_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && internal_link_error |=> module_status_led == `LED_COLOR_RED)
        else $error("module led not red on link error");
    ready_green_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !internal_link_error && !comm_fault && !no_controller
        && !identify_active |=> module_status_led == `LED_COLOR_GREEN)
        else $error("module led not green when ready");
    never_dark_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !comm_fault && !no_controller && !identify_active
        |=> module_status_led != `LED_COLOR_OFF)
        else $error("module led dark while operating");
    net_red_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && module_error |=> network_status_led == `LED_COLOR_RED)
        else $error("network led not red on error");
    no_ip_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && !identify_active && !param_backup_busy
        && !dhcp_busy && !ip_valid |=> network_status_led == `LED_COLOR_OFF)
        else $error("network led lit without ip");
    net_green_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && !identify_active && !param_backup_busy
        && !dhcp_busy && ip_valid && !dup_ip && port_link != 2'h0 |=> network_status_led == `LED_COLOR_GREEN)
        else $error("network led not green when connected");
    link_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && !port_link[0] |=> port_a_link_led == `LED_COLOR_OFF)
        else $error("port a led lit without link");
    link_fast_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && port_link[1] && port_fast[1] |=> port_b_link_led != `LED_COLOR_YELLOW
        && port_b_link_led != `LED_COLOR_RED)
        else $error("port b led wrong colour at 100");
    slow_yellow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && port_link[0] && !port_fast[0] |=> port_a_link_led != `LED_COLOR_GREEN)
        else $error("port a led green at 10");
    selftest_alt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_selftest |=> module_status_led != network_status_led)
        else $error("status leds not alternating in self test");

    // flicker follows step bit 0 one edge later
    flicker_red_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !internal_link_error && comm_fault && flicker
        |=> module_status_led == `LED_COLOR_RED)
        else $error("module led not red in flicker");
    flicker_dark_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !internal_link_error && comm_fault && !flicker
        |=> module_status_led == `LED_COLOR_OFF)
        else $error("module led not dark in flicker");

    single_lit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !internal_link_error && !comm_fault && no_controller
        && step == '0 |=> module_status_led == `LED_COLOR_RED)
        else $error("single flash missing");
    single_dark_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !internal_link_error && !comm_fault && no_controller
        && step != '0 |=> module_status_led == `LED_COLOR_OFF)
        else $error("single flash too long");

    net_flicker_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && (identify_active || param_backup_busy)
        && flicker |=> network_status_led == `LED_COLOR_GREEN)
        else $error("network led not green in flicker");
    net_flicker_dark_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && (identify_active || param_backup_busy)
        && !flicker |=> network_status_led == `LED_COLOR_OFF)
        else $error("network led not dark in flicker");

    // every counted group starts lit at step 0 and is dark past its last flash
    dhcp_lit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && !identify_active && !param_backup_busy
        && dhcp_busy && step == '0 |=> network_status_led == `LED_COLOR_GREEN)
        else $error("dhcp group not lit");
    dhcp_gap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && !identify_active && !param_backup_busy
        && dhcp_busy && step >= {1'b0, `LED_FLASHES_DHCP, 1'b0} |=> network_status_led == `LED_COLOR_OFF)
        else $error("dhcp group too long");

    dup_lit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && !identify_active && !param_backup_busy
        && !dhcp_busy && ip_valid && dup_ip && step == '0 |=> network_status_led == `LED_COLOR_GREEN)
        else $error("duplicate ip group not lit");
    dup_gap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && !identify_active && !param_backup_busy
        && !dhcp_busy && ip_valid && dup_ip && step >= {1'b0, `LED_FLASHES_DUPIP, 1'b0}
        |=> network_status_led == `LED_COLOR_OFF)
        else $error("duplicate ip group too long");

    noport_lit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && !identify_active && !param_backup_busy
        && !dhcp_busy && ip_valid && !dup_ip && port_link == 2'h0 && step == '0
        |=> network_status_led == `LED_COLOR_GREEN)
        else $error("unplugged group not lit");
    noport_gap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && !modbus_only && !module_error && !identify_active && !param_backup_busy
        && !dhcp_busy && ip_valid && !dup_ip && port_link == 2'h0 && step >= {1'b0, `LED_FLASHES_NOPORT, 1'b0}
        |=> network_status_led == `LED_COLOR_OFF)
        else $error("unplugged group too long");

    modbus_ready_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && modbus_only && module_ready |=> module_status_led == `LED_COLOR_GREEN)
        else $error("modbus scheme module led not green");
    modbus_fault_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && modbus_only && !module_ready |=> module_status_led == `LED_COLOR_RED)
        else $error("modbus scheme module led not red");
    modbus_noip_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_run && modbus_only && !ip_valid |=> network_status_led == `LED_COLOR_OFF)
        else $error("modbus scheme network led lit");

    // activity blanks the lamp in the low half of each blink period
    act_dark_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && port_link[0] && act_hold[0] && !blink |=> port_a_link_led == `LED_COLOR_OFF)
        else $error("port a led lit in blink gap");
    fast_lit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && port_link[1] && port_fast[1] && (!act_hold[1] || blink) |=> port_b_link_led == `LED_COLOR_GREEN)
        else $error("port b led not green at 100");
    slow_lit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && port_link[0] && !port_fast[0] && (!act_hold[0] || blink) |=> port_a_link_led == `LED_COLOR_YELLOW)
        else $error("port a led not yellow at 10");

    // enable low must freeze the pattern timers and both status lamps
    freeze_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !clk_en |=> $stable(step) && $stable(prescale) && $stable(module_status_led) && $stable(network_status_led))
        else $error("state moved with enable low");
    prescale_wrap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && tick |=> prescale == '0)
        else $error("prescaler did not wrap on tick");
    prescale_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && !tick |=> prescale == $past(prescale) + 32'h1)
        else $error("prescaler skipped a count");
    step_wrap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && tick && step == `LED_GROUP_LEN |=> step == '0)
        else $error("step did not wrap at group end");

    selftest_end_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        clk_en && phase == led_selftest && tick && selftest_cnt == `LED_SELFTEST_TICKS - 1 |=> phase == led_run)
        else $error("self test did not end on time");
    run_stays_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        phase == led_run |=> phase == led_run)
        else $error("self test restarted without reset");

endmodule
`default_nettype wire

/* File: status_led_pkg.sv */
// types for the fieldbus status indicator
`default_nettype none
package status_led_pkg;
    typedef enum logic [1:0] {
        led_selftest,
        led_run
    } led_phase_type;
endpackage
`default_nettype wire

/* File: tb_top.sv */
// bench for the status indicator: drives conditions, judges lamp patterns
`include "status_led_consts.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] off = `LED_COLOR_OFF, grn = `LED_COLOR_GREEN;
    localparam logic [1:0] red = `LED_COLOR_RED, yel = `LED_COLOR_YELLOW;
    logic clk_sys = 1'h0, resetn = 1'h0, en = 1'h1, clear = 1'h0, lerr = 1'h0, cf = 1'h0, nc = 1'h0;
    logic mb = 1'h0, rdy = 1'h0, idn = 1'h0, bk = 1'h0, ip = 1'h0, me = 1'h0, dup = 1'h0, dhcp = 1'h0;
    logic [1:0] lnk = 2'h0, fast = 2'h0, act = 2'h0, col = 2'h0, sel = 2'h0, md, nt, pa, pb, pcode;
    logic [7:0] rises, changes;
    int err_count = 0, n_compared = 0;
    always #2 clk_sys = ~clk_sys;
    assign pcode = (sel == 2'h0) ? md : (sel == 2'h1) ? nt : pa;
    status_led_indicator #(.TICK_CYCLES(4)) status_led_indicator_i (.clk_sys(clk_sys), .resetn(resetn),
        .clk_en(en), .internal_link_error(lerr), .module_ready(rdy), .comm_fault(cf), .no_controller(nc),
        .modbus_only(mb), .identify_active(idn), .param_backup_busy(bk), .ip_valid(ip), .module_error(me),
        .dup_ip(dup), .dhcp_busy(dhcp), .port_link(lnk), .port_fast(fast), .port_activity(act),
        .module_status_led(md), .network_status_led(nt), .port_a_link_led(pa), .port_b_link_led(pb));
    led_panel led_panel_i (.clk_sys(clk_sys), .clear(clear), .code(pcode), .colour(col),
        .rises(rises), .changes(changes));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // settle past the input change, then watch exactly one 32-tick group
    task automatic win(input logic [1:0] s, input logic [1:0] c);
        repeat (8) @(negedge clk_sys);
        sel = s;
        col = c;
        clear = 1'h1;
        @(negedge clk_sys);
        clear = 1'h0;
        repeat (128) @(negedge clk_sys);
    endtask
    task automatic steady(input logic [1:0] s, input logic [1:0] c);
        win(s, c);
        check({6'h00, pcode}, {6'h00, c});
        check(rises, 8'h00);
        check(changes, 8'h00);
    endtask
    task automatic flashes(input logic [1:0] s, input logic [1:0] c, input logic [7:0] n);
        win(s, c);
        check(rises, n);
    endtask
    task automatic t_selftest;
        check({md, nt, pa, pb}, {grn, red, off, off});
        resetn = 1'h1;
        repeat (7) begin
            repeat (4) @(negedge clk_sys);
            check({6'h00, md ^ nt}, 8'h03);
        end
        repeat (12) @(negedge clk_sys);
        $display("test selftest done");
    endtask
    task automatic t_module;
        steady(2'h0, grn);
        lerr = 1'h1;
        cf = 1'h1;
        steady(2'h0, red);
        lerr = 1'h0;
        flashes(2'h0, red, 8'h10);
        cf = 1'h0;
        nc = 1'h1;
        flashes(2'h0, red, 8'h01);
        nc = 1'h0;
        mb = 1'h1;
        steady(2'h0, red);
        rdy = 1'h1;
        steady(2'h0, grn);
        mb = 1'h0;
        $display("test module done");
    endtask
    task automatic t_network;
        ip = 1'h1;
        idn = 1'h1;
        flashes(2'h1, grn, 8'h10);
        idn = 1'h0;
        bk = 1'h1;
        flashes(2'h1, grn, 8'h10);
        bk = 1'h0;
        me = 1'h1;
        steady(2'h1, red);
        me = 1'h0;
        dhcp = 1'h1;
        flashes(2'h1, grn, 8'h05);
        dhcp = 1'h0;
        ip = 1'h0;
        steady(2'h1, off);
        ip = 1'h1;
        lnk = 2'h2;
        dup = 1'h1;
        flashes(2'h1, grn, 8'h04);
        en = 1'h0;
        win(2'h1, grn);
        check(changes, 8'h00);
        en = 1'h1;
        dup = 1'h0;
        steady(2'h1, grn);
        lnk = 2'h0;
        flashes(2'h1, grn, 8'h03);
        $display("test network done");
    endtask
    task automatic t_link;
        lnk = 2'h3;
        fast = 2'h3;
        steady(2'h2, grn);
        check({6'h00, pb}, {6'h00, grn});
        fast = 2'h0;
        steady(2'h2, yel);
        check({6'h00, pb}, {6'h00, yel});
        act = 2'h1;
        fast = 2'h1;
        flashes(2'h2, grn, 8'h04);
        fast = 2'h0;
        flashes(2'h2, yel, 8'h04);
        act = 2'h0;
        lnk = 2'h0;
        steady(2'h2, off);
        check({6'h00, pb}, {6'h00, off});
        $display("test link done");
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        t_selftest();
        t_module();
        t_network();
        t_link();
        results();
    end
endmodule
`default_nettype wire
